// ### bench/link_side_model.sv
/*
  far side of the block: bus clock that runs only inside frames, and
  the pull-up on the open-drain output-good line.
  assumes the bench raises frame_i around the early register and margining traffic and lowers it for the protection tests.
*/
`timescale 1ns/1ps
`default_nettype none
module link_side_model (
  // frame marker and pin drive
  input  wire logic frame_i,
  input  wire logic good_pin_o,
  input  wire logic good_pin_oe_o,
  // resolved lines
  output var  logic link_clk_o,
  output wire logic good_level_o
);
  // idle high between frames, 160 ns period inside them
  initial link_clk_o = 1'b1;
  always #80 link_clk_o = frame_i ? ~link_clk_o : 1'b1;
  // pull-up wins whenever nobody pulls low
  assign good_level_o = good_pin_oe_o ? good_pin_o : 1'b1;
endmodule
`default_nettype wire

// ### bench/margin_protect_monitor.sv
/*
  port-level checker for the margin, protection and output-good block.
  assumes it is bound to margin_protect_output_good_indicator and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module margin_protect_monitor #(
  parameter logic FIXED_OC_REV = 1'b0 // unused here, kept in step
) (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // command port
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  cmd_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic        rvalid_o,
  // sensors and controls
  input wire logic        ot_fault_i,
  input wire logic        run_o,
  input wire logic        nv_store_o,
  input wire logic        good_pin_o,
  input wire logic        good_pin_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // read answers come exactly one cycle later, data holds between reads
  AST_READ_ANSWER: assert property (rd_i |=> rvalid_o) else $error("read not answered");
  AST_READ_ONLY: assert property (!rd_i |=> !rvalid_o) else $error("stray read valid");
  AST_READ_HOLD: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved");
  // store pulse follows the store command and nothing else
  AST_STORE_PULSE: assert property (wr_i && cmd_i == margin_protect_pkg::IDX_STORE_ALL
    |=> nv_store_o) else $error("store pulse missing");
  AST_STORE_ONLY: assert property (!(wr_i && cmd_i == margin_protect_pkg::IDX_STORE_ALL)
    |=> !nv_store_o) else $error("stray store pulse");
  // open drain: the pin is only ever pulled low
  AST_DRAIN_ONLY: assert property (good_pin_o == 1'b0)
    else $error("good pin driven high");
  // sync delay of the sensor is covered by five cycles of heat
  AST_HOT_NOT_GOOD: assert property (ot_fault_i [*5] |-> good_pin_oe_o)
    else $error("good while hot");
  AST_OFF_STOPS: assert property (wr_i && cmd_i == margin_protect_pkg::IDX_OPERATION
    && !wdata_i[7] |-> ##[1:3] !run_o) else $error("output kept running");
endmodule
bind margin_protect_output_good_indicator margin_protect_monitor #(.FIXED_OC_REV(FIXED_OC_REV)) mon (.sys_clk_i,
  .rst_i, .wr_i, .rd_i, .cmd_i, .wdata_i, .rdata_o, .rvalid_o, .ot_fault_i, .run_o, .nv_store_o,
  .good_pin_o, .good_pin_oe_o);
`default_nettype wire

// ### bench/margin_protect_output_good_indicator_tb.sv
/*
  self-checking bench for margin_protect_output_good_indicator: defaults, field masks,
  margining, output-good window, fault responses and temperature status.
  assumes the package command codes and a 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module margin_protect_output_good_indicator_tb;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, frame = 1'b0;
  logic [7:0]  cmd_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, vout_meas_i = 16'h04cc, vin_meas_i = 16'h0030;
  logic        oc_i = 1'b0, ot_fault_i = 1'b0, ot_warn_i = 1'b0;
  logic        link_clk_i, rvalid_o, run_o, oc_warn_level_o, nv_store_o, good_pin_o, good_pin_oe_o;
  wire logic   good_pin_i;
  logic [15:0] rdata_o, setpoint_o, d;
  int          fails = 0, compares = 0, m, t;
  logic [7:0]  rc[11] = '{8'h01, 8'h25, 8'h26, 8'h4a, 8'h35, 8'h36, 8'h5e, 8'h5f, 8'h41, 8'h45, 8'h00};
  logic [15:0] rv[11] = '{16'h0080, 16'h0500, 16'h0400, 16'hf86f, 16'hf012, 16'hf010, 16'h046a,
                          16'h0452, 16'h0080, 16'h0080, 16'h0000};
  logic [7:0]  ops[6] = '{8'h80, 8'h8c, 8'h94, 8'h98, 8'ha4, 8'ha8};
  logic [15:0] opv[6] = '{16'h04cc, 16'h04cc, 16'h0400, 16'h0400, 16'h0500, 16'h0500};
  logic [15:0] vo[6] = '{16'h04cc, 16'h0440, 16'h0460, 16'h04cc, 16'h0550, 16'h04cc};
  logic        oe[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  always #10 sys_clk_i = ~sys_clk_i;
  margin_protect_output_good_indicator #(.FIXED_OC_REV(1'b0)) uut (.sys_clk_i, .rst_i, .link_clk_i, .wr_i, .rd_i,
    .cmd_i, .wdata_i, .rdata_o, .rvalid_o, .vout_meas_i, .vin_meas_i, .oc_i, .ot_fault_i,
    .ot_warn_i, .setpoint_o, .run_o, .oc_warn_level_o, .nv_store_o, .good_pin_i, .good_pin_o,
    .good_pin_oe_o);
  link_side_model far (.frame_i(frame), .good_pin_o, .good_pin_oe_o, .link_clk_o(link_clk_i),
    .good_level_o(good_pin_i));
  // verdict and end of run, also reached from a hung wait
  task automatic conclude();
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  // one write, held for exactly the taking edge
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    @(negedge sys_clk_i);
    wr_i = 1'b1;
    cmd_i = c;
    wdata_i = v;
    @(negedge sys_clk_i);
    wr_i = 1'b0;
  endtask
  // read answer stands one cycle, seen at the following falling edge
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    @(negedge sys_clk_i);
    rd_i = 1'b1;
    cmd_i = c;
    @(negedge sys_clk_i);
    rd_i = 1'b0;
    chk1(rvalid_o, 1'b1);
    chk(rdata_o, e);
  endtask
  // bounded wait on run or good drive, after the sync delay
  task automatic wait_bit(input logic sel, input logic v);
    int n;
    n = 0;
    repeat (4) @(negedge sys_clk_i);
    while ((sel ? run_o : good_pin_oe_o) !== v && n < 400) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk1(sel ? run_o : good_pin_oe_o, v);
    // a used-up bound is a mismatch of its own
    if (n == 400) begin
      fails++;
      conclude();
    end
  endtask
  // half-volt input level clamped into its allowed span
  function automatic logic [15:0] vin_exp(input int mm, input int lo);
    int v;
    v = (mm > 56) ? 56 : ((mm < lo) ? lo : mm);
    return {margin_protect_pkg::EXP_VIN, 11'(v)};
  endfunction
  initial begin
    void'($urandom(32'h2b6e));
    repeat (4) @(negedge sys_clk_i);
    rst_i = 1'b0;
    frame = 1'b1;
    for (int i = 0; i < 11; i++) rd(rc[i], rv[i]);
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom) | 16'h8000;
      wr(rc[(i < 2) ? i + 1 : i + 4], d);
      rd(rc[(i < 2) ? i + 1 : i + 4], {1'b0, d[14:0]});
      wr(rc[(i < 2) ? i + 1 : i + 4], rv[(i < 2) ? i + 1 : i + 4]);
      wr(8'h4a, {margin_protect_pkg::EXP_OC, d[10:0]});
      rd(8'h4a, {margin_protect_pkg::EXP_OC, 5'h00, d[5:0]});
      m = (i == 0) ? 0 : ((i == 1) ? 70 : 2 * $urandom_range(0, 35));
      wr(8'h35, {margin_protect_pkg::EXP_VIN, 11'(m)});
      rd(8'h35, vin_exp(m, 14));
      wr(8'h36, {margin_protect_pkg::EXP_VIN, 11'(m)});
      rd(8'h36, vin_exp(m, 12));
    end
    wr(8'h35, margin_protect_pkg::RST_INPUT_TURN_ON_LEVEL);
    wr(8'h36, margin_protect_pkg::RST_INPUT_TURN_OFF_LEVEL);
    wr(8'h11, 16'h0000);
    // no converter model: margins move the setpoint, not vout, so faults must not latch
    wr(8'h41, 16'h0000);
    wr(8'h45, 16'h0000);
    t = $urandom_range(0, 63);
    wr(8'h22, 16'(t));
    for (int i = 0; i < 6; i++) begin
      wr(8'h01, {8'h00, ops[i]});
      repeat (2) @(negedge sys_clk_i);
      chk(setpoint_o, opv[i] + 16'(t));
    end
    // trim past the window is clamped to its edge, nominal 1228
    wr(8'h22, 16'h0400);
    repeat (2) @(negedge sys_clk_i);
    chk(setpoint_o, 16'(1228 + 1228 / 4));
    wr(8'h22, 16'hfc00);
    wr(8'h01, 16'h0098);
    repeat (2) @(negedge sys_clk_i);
    chk(setpoint_o, 16'(1228 - 1228 / 4));
    wr(8'h22, 16'h0000);
    wr(8'h45, 16'h0080);
    frame = 1'b0;
    wr(8'h01, 16'h0000);
    wait_bit(1'b1, 1'b0);
    wr(8'h01, 16'h0080);
    wait_bit(1'b1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      vout_meas_i = vo[i];
      wait_bit(1'b0, oe[i]);
    end
    wr(8'h41, 16'h0000);
    vout_meas_i = 16'h0600;
    repeat (20) @(negedge sys_clk_i);
    chk1(run_o, 1'b1);
    wr(8'h41, 16'h00c0);
    wait_bit(1'b1, 1'b0);
    vout_meas_i = 16'h04cc;
    wait_bit(1'b1, 1'b1);
    wr(8'h41, 16'h0080);
    vout_meas_i = 16'h0600;
    wait_bit(1'b1, 1'b0);
    // delayed stop: still running two switching cycles in, stopped later
    wr(8'h41, 16'h0000);
    wait_bit(1'b1, 1'b1);
    wr(8'h41, 16'h0040);
    repeat (2 * margin_protect_pkg::SWITCH_CYC) @(negedge sys_clk_i);
    chk1(run_o, 1'b1);
    wait_bit(1'b1, 1'b0);
    wr(8'h41, 16'h0000);
    vout_meas_i = 16'h04cc;
    wait_bit(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      {ot_fault_i, ot_warn_i} = 2'(i);
      repeat (5) @(negedge sys_clk_i);
      chk1(good_pin_oe_o, i >= 2);
      rd(8'h7d, {8'h00, 2'(i), 6'h00});
    end
    {ot_fault_i, ot_warn_i, oc_i} = 3'h1;
    repeat (5) @(negedge sys_clk_i);
    chk1(oc_warn_level_o, 1'b1);
    chk1(good_pin_oe_o, 1'b1);
    oc_i = 1'b0;
    wait_bit(1'b0, 1'b0);
    // trip levels read back as a ratio of nominal, writes snap to the nearest
    rd(8'h40, 16'(1228 * 112 / 100));
    rd(8'h44, 16'(1228 * 88 / 100));
    wr(8'h40, 16'(1228 * 1095 / 1000));
    rd(8'h40, 16'(1228 * 110 / 100));
    wr(8'h44, 16'(1228 * 87 / 100));
    rd(8'h44, 16'(1228 * 88 / 100));
    conclude();
  end
endmodule
`default_nettype wire

// ### verilog/margin_protect_output_good_indicator.sv
/*
  configuration and supervision logic of a digitally managed step-down
  module: margining, overcurrent warning, temperature status, output
  over/under-voltage trip levels and responses, input turn-on/off levels
  and the open-drain output-good indicator.
  assumes a pmbus slave engine in front of it that delivers whole command
  writes as wr_i pulses (command code plus 16 bit data) and reads as
  rd_i pulses; voltage readings arrive as 16 bit words from another clock domain.
  the link clock input is sampled and synchronised here.
*/
// Notes on behaviour
// - margin words exponent -10, top bit zero
// - margin setpoint is margin plus trim
// - margin plus trim kept within 25 percent
// - store-all copies margins, oc limit, good levels
// - operation bits 5:2 select margin mode
// - oc limit exponent -1, six writable bits
// - oc limit defaults 55.5 A, later fixed 57 A
// - temperature status reports fault and warning
// - ov ratio 108/110/112/115, default 112
// - uv ratio 92/90/88/85, default 88
// - trip words rounded to nearest ratio
// - response 00 keeps converter running
// - response 01 waits four cycles then stops
// - response 10 stops at once
// - response 11 disables while fault persists
// - input levels half volt steps, clamped range
// - input words exponent -2, top four zero
// - output-good low on temp, current, regulation
// - good-on sets lower level, mirrored above
// - good-off sets deassert level, mirrored above
// - good words exponent -10, top bit zero
// - good levels reset 1.1035 V and 1.08 V
// - operation bit 7 enables output
// - trim is signed offset added to setpoint
`timescale 1ns/1ps
`default_nettype none
module margin_protect_output_good_indicator #(
  parameter logic FIXED_OC_REV = 1'b0 // later revision: fixed oc limit
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // link clock from the pmbus engine, sampled only
  input  wire logic        link_clk_i,
  // command port from the pmbus engine
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o,
  output logic             rvalid_o,
  // measurements and sensors (asynchronous)
  input  wire logic [15:0] vout_meas_i,
  input  wire logic [15:0] vin_meas_i,
  input  wire logic        oc_i,
  input  wire logic        ot_fault_i,
  input  wire logic        ot_warn_i,
  // converter controls
  output logic      [15:0] setpoint_o,
  output logic             run_o,
  output logic             oc_warn_level_o,
  output logic             nv_store_o,
  // open-drain output-good indicator
  input  wire logic        good_pin_i,
  output logic             good_pin_o,
  output logic             good_pin_oe_o
);
  // registers
  logic [7:0]  operation_control;
  logic [15:0] vout_trim;
  logic [15:0] margin_high_setpoint, margin_low_setpoint;
  logic [15:0] scale_loop;
  logic [15:0] overcurrent_warning_threshold;
  logic [1:0]  ov_sel, uv_sel;              // selected ratio index
  logic [7:0]  overvoltage_fault_action, undervoltage_fault_action;
  logic [15:0] input_turn_on_level, input_turn_off_level;
  logic [15:0] good_assert_threshold, good_deassert_threshold;
  // synchronisers for outside signals
  logic [4:0]  sync_a, sync_b;
  logic [15:0] vout_a, vout_b, vin_a, vin_b;
  logic        link_q;
  logic        link_rise;                    // link clock edge seen
  logic [15:0] nominal, next_setpoint;
  logic [7:0]  ov_pct, uv_pct;
  logic        ov_now, uv_now, in_window;
  logic        ov_stop, uv_stop, vin_ok;
  logic [15:0] swdiv;                        // switching-cycle divider
  logic        sw_tick;
  logic [3:0]  ov_cnt, uv_cnt;

  // ratio selection from a written trip word, nearest of four
  function automatic logic [1:0] pick_ratio(input logic [15:0] word,
      input logic [15:0] nom, input logic ov);
    logic [31:0] pml;                        // word in tenths of a percent of nominal
    pml = 32'h0;
    pml = (nom == 16'h0) ? 32'h0 : (32'(word) * 32'd1000) / 32'(nom);
    // thresholds at the midpoints, tenths keep 86.9 percent on the 88 side
    if (ov) begin
      pick_ratio = (pml < 32'd1090) ? 2'h0 : (pml < 32'd1110) ? 2'h1 :
                   (pml < 32'd1135) ? 2'h2 : 2'h3;
    end else begin
      pick_ratio = (pml > 32'd910) ? 2'h0 : (pml > 32'd890) ? 2'h1 :
                   (pml > 32'd865) ? 2'h2 : 2'h3;
    end
  endfunction

  // clamp an input level mantissa to half volt steps in range
  function automatic logic [15:0] vin_level(input logic [15:0] word,
      input logic [10:0] lo);
    logic [10:0] m;
    m = word[10:0];
    if (word[15:11] != margin_protect_pkg::EXP_VIN) m = 11'h0;
    if (m < lo) m = lo;
    if (m > 11'd56) m = 11'd56;
    m = {m[10:1], 1'b0};
    vin_level = {margin_protect_pkg::EXP_VIN, 4'h0, m[6:0]};
  endfunction

  // sensors pass two flops before use
  always_ff @(posedge sys_clk_i) begin
    sync_a <= {link_clk_i, oc_i, ot_fault_i, ot_warn_i, good_pin_i};
    sync_b <= sync_a;
    vout_a <= vout_meas_i;
    vout_b <= vout_a;
    vin_a  <= vin_meas_i;
    vin_b  <= vin_a;
    link_q <= sync_b[4];
  end
  assign link_rise = sync_b[4] & ~link_q;

  // nominal output from the divider ratio: vref 0.6 V / ratio
  assign nominal = (scale_loop[10:0] == 11'h0) ? 16'h0 :
                   16'((32'd614 * 32'd512) / 32'(scale_loop[10:0]));

  // register writes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      operation_control <= margin_protect_pkg::RST_OPERATION;
      vout_trim <= margin_protect_pkg::RST_TRIM;
      margin_high_setpoint <= margin_protect_pkg::RST_MARGIN_HI;
      margin_low_setpoint <= margin_protect_pkg::RST_MARGIN_LO;
      scale_loop <= margin_protect_pkg::RST_SCALE;
      overcurrent_warning_threshold <= FIXED_OC_REV ?
        margin_protect_pkg::FIXED_OC_WARN : margin_protect_pkg::RST_OC_WARN;
      ov_sel <= margin_protect_pkg::RATIO_DEFAULT;
      uv_sel <= margin_protect_pkg::RATIO_DEFAULT;
      overvoltage_fault_action <= margin_protect_pkg::RST_ACTION;
      undervoltage_fault_action <= margin_protect_pkg::RST_ACTION;
      input_turn_on_level <= margin_protect_pkg::RST_INPUT_TURN_ON_LEVEL;
      input_turn_off_level <= margin_protect_pkg::RST_INPUT_TURN_OFF_LEVEL;
      good_assert_threshold <= margin_protect_pkg::RST_GOOD_ON;
      good_deassert_threshold <= margin_protect_pkg::RST_GOOD_OFF;
    end else if (wr_i) begin
      case (cmd_i)
        margin_protect_pkg::IDX_OPERATION: operation_control <= wdata_i[7:0];
        margin_protect_pkg::IDX_TRIM: vout_trim <= wdata_i;
        margin_protect_pkg::IDX_MARGIN_HIGH:
          margin_high_setpoint <= {1'b0, wdata_i[14:0]};
        margin_protect_pkg::IDX_MARGIN_LOW:
          margin_low_setpoint <= {1'b0, wdata_i[14:0]};
        margin_protect_pkg::IDX_SCALE_LOOP: scale_loop <= wdata_i;
        margin_protect_pkg::IDX_OC_WARN: begin
          // later revision ignores the write
          if (!FIXED_OC_REV) begin
            overcurrent_warning_threshold <=
              {margin_protect_pkg::EXP_OC, 5'h0, wdata_i[5:0]};
          end
        end
        margin_protect_pkg::IDX_OV_LEVEL: ov_sel <= pick_ratio(wdata_i, nominal, 1'b1);
        margin_protect_pkg::IDX_UV_LEVEL: uv_sel <= pick_ratio(wdata_i, nominal, 1'b0);
        margin_protect_pkg::IDX_OV_ACTION: overvoltage_fault_action <= wdata_i[7:0];
        margin_protect_pkg::IDX_UV_ACTION: undervoltage_fault_action <= wdata_i[7:0];
        margin_protect_pkg::IDX_INPUT_TURN_ON_LEVEL: input_turn_on_level <= vin_level(wdata_i, 11'd14);
        margin_protect_pkg::IDX_INPUT_TURN_OFF_LEVEL: input_turn_off_level <= vin_level(wdata_i, 11'd12);
        margin_protect_pkg::IDX_GOOD_ON:
          good_assert_threshold <= {1'b0, wdata_i[14:0]};
        margin_protect_pkg::IDX_GOOD_OFF:
          good_deassert_threshold <= {1'b0, wdata_i[14:0]};
        default: ; // unknown command: ignored
      endcase
    end
  end

  // store-all pulse toward the non-volatile copy engine
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) nv_store_o <= 1'b0;
    else nv_store_o <= wr_i && cmd_i == margin_protect_pkg::IDX_STORE_ALL;
  end

  // register reads, answer one cycle later
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o  <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        case (cmd_i)
          margin_protect_pkg::IDX_OPERATION: rdata_o <= {8'h00, operation_control};
          margin_protect_pkg::IDX_TRIM: rdata_o <= vout_trim;
          margin_protect_pkg::IDX_MARGIN_HIGH: rdata_o <= margin_high_setpoint;
          margin_protect_pkg::IDX_MARGIN_LOW: rdata_o <= margin_low_setpoint;
          margin_protect_pkg::IDX_SCALE_LOOP: rdata_o <= scale_loop;
          margin_protect_pkg::IDX_OC_WARN: rdata_o <= overcurrent_warning_threshold;
          margin_protect_pkg::IDX_OV_LEVEL: rdata_o <= 16'((32'(nominal) * 32'(ov_pct)) / 32'd100);
          margin_protect_pkg::IDX_UV_LEVEL: rdata_o <= 16'((32'(nominal) * 32'(uv_pct)) / 32'd100);
          margin_protect_pkg::IDX_OV_ACTION: rdata_o <= {8'h00, overvoltage_fault_action};
          margin_protect_pkg::IDX_UV_ACTION: rdata_o <= {8'h00, undervoltage_fault_action};
          margin_protect_pkg::IDX_INPUT_TURN_ON_LEVEL: rdata_o <= input_turn_on_level;
          margin_protect_pkg::IDX_INPUT_TURN_OFF_LEVEL: rdata_o <= input_turn_off_level;
          margin_protect_pkg::IDX_GOOD_ON: rdata_o <= good_assert_threshold;
          margin_protect_pkg::IDX_GOOD_OFF: rdata_o <= good_deassert_threshold;
          margin_protect_pkg::IDX_STATUS_TEMP:
            rdata_o <= {8'h00, sync_b[2], sync_b[1], 6'h00};
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // setpoint: margin or nominal plus trim, held inside 25 percent
  always_comb begin
    logic [16:0] base, sum, lo, hi, win;
    base = {1'b0, nominal};
    sum = 17'h0;
    lo = 17'h0;
    hi = 17'h0;
    win = 17'h0;
    case (operation_control[margin_protect_pkg::OP_MARGIN_HI:margin_protect_pkg::OP_MARGIN_LO])
      margin_protect_pkg::MARGIN_LOW_IGNORE,
      margin_protect_pkg::MARGIN_LOW_ACT: base = {1'b0, margin_low_setpoint};
      margin_protect_pkg::MARGIN_HIGH_IGNORE,
      margin_protect_pkg::MARGIN_HIGH_ACT: base = {1'b0, margin_high_setpoint};
      default: base = {1'b0, nominal};
    endcase
    sum = 17'(base + {vout_trim[15], vout_trim});
    win = 17'((32'(nominal) * 32'(margin_protect_pkg::TRIM_WINDOW_PCT)) / 32'd100);
    lo = 17'({1'b0, nominal} - win);
    hi = 17'({1'b0, nominal} + win);
    if (sum[16] || sum < lo) sum = lo;
    if (sum > hi) sum = hi;
    next_setpoint = sum[15:0];
  end

  // comparison of measured output against trip levels
  always_comb begin
    case (ov_sel)
      2'h0: ov_pct = margin_protect_pkg::OV_PCT_0;
      2'h1: ov_pct = margin_protect_pkg::OV_PCT_1;
      2'h2: ov_pct = margin_protect_pkg::OV_PCT_2;
      default: ov_pct = margin_protect_pkg::OV_PCT_3;
    endcase
    case (uv_sel)
      2'h0: uv_pct = margin_protect_pkg::UV_PCT_0;
      2'h1: uv_pct = margin_protect_pkg::UV_PCT_1;
      2'h2: uv_pct = margin_protect_pkg::UV_PCT_2;
      default: uv_pct = margin_protect_pkg::UV_PCT_3;
    endcase
  end
  // trip points scale the setpoint; ignore-fault margin masks them
  assign ov_now = (32'(vout_b) * 32'd100 > 32'(setpoint_o) * 32'(ov_pct)) &&
                  !(operation_control[3:2] == 2'h1 && operation_control[5:4] != 2'h0);
  assign uv_now = (32'(vout_b) * 32'd100 < 32'(setpoint_o) * 32'(uv_pct)) && run_o &&
                  !(operation_control[3:2] == 2'h1 && operation_control[5:4] != 2'h0);
  assign vin_ok = ({1'b0, vin_b[10:0]} >= {1'b0, input_turn_off_level[10:0]});

  // switching-cycle tick from the clock divider
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || swdiv == 16'(margin_protect_pkg::SWITCH_CYC - 1)) swdiv <= 16'h0;
    else swdiv <= 16'(swdiv + 16'h1);
  end
  assign sw_tick = (swdiv == 16'h0);

  // overvoltage response engine
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ov_stop <= 1'b0;
      ov_cnt  <= 4'h0;
    end else begin
      case (overvoltage_fault_action[7:6])
        margin_protect_pkg::RESP_CONTINUE: ov_stop <= 1'b0;
        margin_protect_pkg::RESP_DELAYED: begin
          if (!ov_now) ov_cnt <= 4'h0;
          else if (sw_tick && ov_cnt != margin_protect_pkg::DELAY_CYCLES)
            ov_cnt <= 4'(ov_cnt + 4'h1);
          if (ov_now && ov_cnt == margin_protect_pkg::DELAY_CYCLES) ov_stop <= 1'b1;
          else if (!ov_now && overvoltage_fault_action[5:3] == margin_protect_pkg::RESTART_ALWAYS)
            ov_stop <= 1'b0;
        end
        margin_protect_pkg::RESP_IMMEDIATE: begin
          if (ov_now) ov_stop <= 1'b1;
          else if (overvoltage_fault_action[5:3] == margin_protect_pkg::RESTART_ALWAYS)
            ov_stop <= 1'b0;
        end
        default: ov_stop <= ov_now;
      endcase
    end
  end

  // undervoltage response engine, configured independently
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      uv_stop <= 1'b0;
      uv_cnt  <= 4'h0;
    end else begin
      case (undervoltage_fault_action[7:6])
        margin_protect_pkg::RESP_CONTINUE: uv_stop <= 1'b0;
        margin_protect_pkg::RESP_DELAYED: begin
          if (!uv_now) uv_cnt <= 4'h0;
          else if (sw_tick && uv_cnt != margin_protect_pkg::DELAY_CYCLES)
            uv_cnt <= 4'(uv_cnt + 4'h1);
          if (uv_now && uv_cnt == margin_protect_pkg::DELAY_CYCLES) uv_stop <= 1'b1;
          else if (!uv_now && undervoltage_fault_action[5:3] == margin_protect_pkg::RESTART_ALWAYS)
            uv_stop <= 1'b0;
        end
        margin_protect_pkg::RESP_IMMEDIATE: begin
          if (uv_now) uv_stop <= 1'b1;
          else if (undervoltage_fault_action[5:3] == margin_protect_pkg::RESTART_ALWAYS)
            uv_stop <= 1'b0;
        end
        default: uv_stop <= uv_now;
      endcase
    end
  end

  // converter outputs and the output-good window
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      setpoint_o <= 16'h0000;
      run_o <= 1'b0;
      oc_warn_level_o <= 1'b0;
      in_window <= 1'b0;
      good_pin_o <= 1'b0;
      good_pin_oe_o <= 1'b1;
    end else begin
      setpoint_o <= next_setpoint;
      run_o <= operation_control[margin_protect_pkg::OP_ON_BIT] &&
               !ov_stop && !uv_stop && vin_ok;
      oc_warn_level_o <= sync_b[3];
      // hysteresis: assert inside good-on window, drop outside good-off
      if (vout_b >= good_assert_threshold &&
          vout_b <= 16'(2 * nominal - good_assert_threshold))
        in_window <= 1'b1;
      else if (vout_b < good_deassert_threshold ||
               vout_b > 16'(2 * nominal - good_deassert_threshold))
        in_window <= 1'b0;
      good_pin_o <= 1'b0;
      good_pin_oe_o <= !(in_window && run_o && !sync_b[3] && !sync_b[2]);
    end
  end
endmodule
`default_nettype wire

// ### verilog/margin_protect_pkg.sv
/*
  constants for the margin, protection and output-good block:
  register indices, field positions, reset values and timing counts.
  assumes a bench or host that reaches registers by index over the
  documented pmbus command port of the top module.
*/
`default_nettype none
package margin_protect_pkg;
  // register indices on the command port (command codes)
  localparam logic [7:0] IDX_OPERATION      = 8'h01;
  localparam logic [7:0] IDX_STORE_ALL      = 8'h11;
  localparam logic [7:0] IDX_TRIM           = 8'h22;
  localparam logic [7:0] IDX_MARGIN_HIGH    = 8'h25;
  localparam logic [7:0] IDX_MARGIN_LOW     = 8'h26;
  localparam logic [7:0] IDX_SCALE_LOOP     = 8'h29;
  localparam logic [7:0] IDX_OV_LEVEL       = 8'h40;
  localparam logic [7:0] IDX_OV_ACTION      = 8'h41;
  localparam logic [7:0] IDX_OC_WARN        = 8'h4a;
  localparam logic [7:0] IDX_UV_LEVEL       = 8'h44;
  localparam logic [7:0] IDX_UV_ACTION      = 8'h45;
  localparam logic [7:0] IDX_INPUT_TURN_ON_LEVEL         = 8'h35;
  localparam logic [7:0] IDX_INPUT_TURN_OFF_LEVEL        = 8'h36;
  localparam logic [7:0] IDX_GOOD_ON        = 8'h5e;
  localparam logic [7:0] IDX_GOOD_OFF       = 8'h5f;
  localparam logic [7:0] IDX_STATUS_TEMP    = 8'h7d;
  // operation byte fields
  localparam int OP_ON_BIT = 7;
  localparam int OP_MARGIN_HI = 5;
  localparam int OP_MARGIN_LO = 2;
  localparam logic [3:0] MARGIN_LOW_IGNORE  = 4'h5;
  localparam logic [3:0] MARGIN_LOW_ACT     = 4'h6;
  localparam logic [3:0] MARGIN_HIGH_IGNORE = 4'h9;
  localparam logic [3:0] MARGIN_HIGH_ACT    = 4'ha;
  // fault response fields
  localparam logic [1:0] RESP_CONTINUE  = 2'h0;
  localparam logic [1:0] RESP_DELAYED   = 2'h1;
  localparam logic [1:0] RESP_IMMEDIATE = 2'h2;
  localparam logic [2:0] RESTART_ALWAYS = 3'h7;
  localparam logic [3:0] DELAY_CYCLES   = 4'h4;
  // linear exponents, 5 bit two's complement in the top of the word
  localparam logic [4:0] EXP_OC  = 5'h1f; // -1
  localparam logic [4:0] EXP_VIN = 5'h1e; // -2
  // reset values
  localparam logic [7:0]  RST_OPERATION = 8'h80;
  localparam logic [15:0] RST_TRIM      = 16'h0000;
  localparam logic [15:0] RST_MARGIN_HI = 16'h0500;
  localparam logic [15:0] RST_MARGIN_LO = 16'h0400;
  localparam logic [15:0] RST_SCALE     = 16'hb900; // 256 at exponent -9
  localparam logic [15:0] RST_OC_WARN   = {EXP_OC, 11'h06f}; // 55.5 A
  localparam logic [15:0] FIXED_OC_WARN = {EXP_OC, 11'h072}; // 57 A
  localparam logic [15:0] RST_INPUT_TURN_ON_LEVEL    = {EXP_VIN, 11'h012}; // 4.5 V
  localparam logic [15:0] RST_INPUT_TURN_OFF_LEVEL   = {EXP_VIN, 11'h010}; // 4.0 V
  localparam logic [15:0] RST_GOOD_ON   = 16'h046a; // 1.1035 V
  localparam logic [15:0] RST_GOOD_OFF  = 16'h0452; // 1.08 V
  localparam logic [7:0]  RST_ACTION    = 8'h80;
  // ratio selectors, percent of commanded output
  localparam logic [1:0] RATIO_DEFAULT = 2'h2;
  localparam logic [7:0] OV_PCT_0 = 8'd108;
  localparam logic [7:0] OV_PCT_1 = 8'd110;
  localparam logic [7:0] OV_PCT_2 = 8'd112;
  localparam logic [7:0] OV_PCT_3 = 8'd115;
  localparam logic [7:0] UV_PCT_0 = 8'd92;
  localparam logic [7:0] UV_PCT_1 = 8'd90;
  localparam logic [7:0] UV_PCT_2 = 8'd88;
  localparam logic [7:0] UV_PCT_3 = 8'd85;
  localparam logic [7:0] TRIM_WINDOW_PCT = 8'd25;
  // status temperature bits
  localparam int TEMP_FAULT_BIT = 7;
  localparam int TEMP_WARN_BIT  = 6;
  // switching cycle: 1 us period at 50 MHz clock
  localparam int SWITCH_NS  = 1000;
  localparam int CLK_NS     = 20;
  localparam int SWITCH_CYC = SWITCH_NS / CLK_NS;
endpackage
`default_nettype wire
